// File: verilog/serial_host_defines.svh
// constants for the serial host port with frame checking
`ifndef SERIAL_HOST_DEFINES_SVH
`define SERIAL_HOST_DEFINES_SVH
`define FRAME_LONG 6'h20
`define FRAME_SHORT 6'h18
`define CRC_POLY 8'h07
`define CLK_NS 4
`define SYNC_LAT_NS 1220
`define SYNC_CYC 10'(`SYNC_LAT_NS / `CLK_NS)
`define CLK_HZ 250000000
`define BAUD 9600
`define BIT_CYC_DEF 16'(`CLK_HZ / `BAUD)
`define RW_BIT 23
`define ADDR_HI 22
`define ADDR_LO 16
`define MAP_BIT 0
`define UBM_REG_ADDR 7'h7f
`define FAULT_REG_ADDR 7'h20
`define GEN_REG_ADDR 7'h21
`define LAST_BYTE 2'h2
`define RX_LAST 4'ha
`define TX_LAST 4'hb
`define STOP_POS 10
`define PAR_POS 9
`endif

// File: verilog/serial_host_pkg.sv
// types shared by the serial host port modules
`default_nettype none
package serial_host_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_BRK, TX_B0, TX_B1, TX_B2} tx_state_t;
    typedef struct packed {
        logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, cs_p, sdi_m, sdi_s;
        logic [31:0] rx_sh;
        logic [5:0] ecnt;
        logic [31:0] out_sh;
        logic [5:0] lcnt;
        logic sdo, pend, p_wr, p_uart, cmd_v;
        logic [9:0] dly;
        logic [6:0] p_addr;
        logic [15:0] p_data;
        logic resp_cmd, resp_crcerr, resp_kind;
        logic [15:0] resp_data;
        logic [1:0] fail_cnt;
        logic fault, clr_pend, sticky_clr, map, uarm;
        logic [1:0] ucnt;
        logic [23:0] ush;
        tx_state_t tx_st;
        logic [23:0] tx_pkt;
        logic tx_rd, ev_pend, ev_p;
    } core_st_t;
    typedef struct packed {
        logic rx_m, rx_s, rx_busy, rx_hold;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [10:0] rx_sh;
        logic rx_valid, rx_break, rx_err;
        logic [7:0] rx_byte;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [11:0] tx_sh;
    } link_st_t;
endpackage
`default_nettype wire

// File: verilog/uart_link_if.sv
// character-level handshake between the port core and its uart
`timescale 1ns/1ps
`default_nettype none
interface uart_link_if;
    logic rx_valid;
    logic rx_break;
    logic rx_err;
    logic [7:0] rx_byte;
    logic tx_valid;
    logic tx_break;
    logic tx_ready;
    logic [7:0] tx_byte;
    modport link (output rx_valid, rx_break, rx_err, rx_byte, tx_ready, input tx_valid, tx_break, tx_byte);
    modport core (input rx_valid, rx_break, rx_err, rx_byte, tx_ready, output tx_valid, tx_break, tx_byte);
endinterface
`default_nettype wire

// File: verilog/uart_link.sv
// break-framed uart character receiver and transmitter
`timescale 1ns/1ps
`default_nettype none
`include "serial_host_defines.svh"
module uart_link #(
    parameter logic [15:0] BIT_CYC = `BIT_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_pin,
    output logic tx_pin,
    uart_link_if.link lnk
);
    import serial_host_pkg::*;
    link_st_t link_q, link_d;

    always_comb begin
        logic [10:0] sh;
        sh = '0;
        link_d = link_q;
        link_d.rx_valid = 1'b0;
        link_d.rx_break = 1'b0;
        link_d.rx_err = 1'b0;
        link_d.rx_m = rx_pin;
        link_d.rx_s = link_q.rx_m;
        // ************************************************
        // receive: sample each bit at its centre
        // ************************************************
        if (link_q.rx_hold && link_q.rx_s) begin
            link_d.rx_hold = 1'b0;
        end
        if (!link_q.rx_busy) begin
            if (!link_q.rx_hold && !link_q.rx_s) begin
                link_d.rx_busy = 1'b1;
                link_d.rx_cnt = {1'b0, BIT_CYC[15:1]};
                link_d.rx_bit = '0;
            end
        end else if (link_q.rx_cnt != '0) begin
            link_d.rx_cnt = link_q.rx_cnt - 16'h0001;
        end else begin
            sh = {link_q.rx_s, link_q.rx_sh[10:1]};
            link_d.rx_sh = sh;
            link_d.rx_cnt = BIT_CYC - 16'h0001;
            link_d.rx_bit = link_q.rx_bit + 4'h1;
            if (link_q.rx_bit == `RX_LAST) begin
                link_d.rx_busy = 1'b0;
                // line must go high again before the next start bit
                link_d.rx_hold = 1'b1;
                link_d.rx_byte = sh[8:1];
                if (sh == '0) begin
                    link_d.rx_break = 1'b1;
                end else if (sh[`STOP_POS] && (^sh[`PAR_POS:1])) begin
                    link_d.rx_valid = 1'b1;
                end else begin
                    link_d.rx_err = 1'b1;
                end
            end
        end
        // ************************************************
        // transmit: idle bit after each character
        // ************************************************
        if (!link_q.tx_busy) begin
            if (lnk.tx_valid) begin
                link_d.tx_busy = 1'b1;
                link_d.tx_cnt = BIT_CYC - 16'h0001;
                link_d.tx_bit = '0;
                if (lnk.tx_break) begin
                    link_d.tx_sh = {1'b1, 11'h000};
                end else begin
                    link_d.tx_sh = {2'b11, ~^lnk.tx_byte, lnk.tx_byte, 1'b0};
                end
            end
        end else if (link_q.tx_cnt != '0) begin
            link_d.tx_cnt = link_q.tx_cnt - 16'h0001;
        end else begin
            link_d.tx_sh = {1'b1, link_q.tx_sh[11:1]};
            link_d.tx_cnt = BIT_CYC - 16'h0001;
            link_d.tx_bit = link_q.tx_bit + 4'h1;
            if (link_q.tx_bit == `TX_LAST) begin
                link_d.tx_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_q <= '0;
            link_q.rx_m <= 1'b1;
            link_q.rx_s <= 1'b1;
        end else begin
            link_q <= link_d;
        end
    end

    assign tx_pin = link_q.tx_busy ? link_q.tx_sh[0] : 1'b1;
    assign lnk.tx_ready = ~link_q.tx_busy;
    assign lnk.rx_valid = link_q.rx_valid;
    assign lnk.rx_break = link_q.rx_break;
    assign lnk.rx_err = link_q.rx_err;
    assign lnk.rx_byte = link_q.rx_byte;
endmodule
`default_nettype wire

// File: verilog/serial_host_port_frame_check.sv
// serial peripheral and break-framed uart command port with frame checking
`timescale 1ns/1ps
`default_nettype none
`include "serial_host_defines.svh"
module serial_host_port_frame_check #(
    parameter logic [15:0] BIT_CYC = `BIT_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk_pin,
    input wire logic cs_n_pin,
    input wire logic sdi_pin,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    input wire logic readback_disable,
    input wire logic fall_edge_launch,
    input wire logic check_enable,
    input wire logic [1:0] frame_check_fail_limit,
    input wire logic fault_mask,
    input wire logic alarm_action_en,
    input wire logic unsolicited_event_enable,
    input wire logic fault_summary,
    input wire logic general_summary,
    input wire logic reset_flag,
    input wire logic [15:0] fault_flag_value,
    input wire logic [15:0] general_flag_value,
    input wire logic [15:0] rd_data,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [6:0] cmd_addr,
    output logic [15:0] cmd_wdata,
    output logic frame_check_fault,
    output logic fault_pin_n,
    output logic break_framed_uart,
    output logic sticky_clear
);
    import serial_host_pkg::*;
    core_st_t core_q, core_d;
    uart_link_if ul ();

    uart_link #(
        .BIT_CYC(BIT_CYC)
    ) u_link (
        .clk(clk),
        .rst_n(rst_n),
        .rx_pin(serial_rx_pin),
        .tx_pin(serial_tx_pin),
        .lnk(ul.link)
    );

    // ************************************************
    // helpers
    // ************************************************
    // msb first, zero start: a frame carrying its own checksum leaves zero
    function automatic logic [7:0] crc8(input logic [31:0] dat);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ dat[i]) ? `CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [7:0] status_byte(input logic cmd, input logic alm, input logic cerr,
                                               input logic gen, input logic kind, input logic rst);
        status_byte = {cmd, alm, cerr, gen, kind, rst, 2'b00};
    endfunction

    always_comb begin
        logic [5:0] flen;
        logic [4:0] eidx;
        logic [23:0] f24;
        logic [23:0] resp24;
        logic bad, fall, rise, launch, alarm, ev, cs_fall, cs_rise;
        flen = check_enable ? `FRAME_LONG : `FRAME_SHORT;
        eidx = 5'(flen - 6'h01);
        f24 = check_enable ? core_q.rx_sh[31:8] : core_q.rx_sh[23:0];
        bad = check_enable && (crc8(core_q.rx_sh) != 8'h00);
        fall = core_q.sclk_p & ~core_q.sclk_s & ~core_q.cs_s;
        rise = ~core_q.sclk_p & core_q.sclk_s & ~core_q.cs_s;
        launch = fall_edge_launch ? fall : rise;
        cs_fall = core_q.cs_p & ~core_q.cs_s;
        cs_rise = ~core_q.cs_p & core_q.cs_s;
        alarm = fault_summary | (core_q.fault & ~fault_mask);
        ev = alarm | general_summary;
        resp24 = '0;
        core_d = core_q;
        core_d.cmd_v = 1'b0;
        core_d.sticky_clr = 1'b0;
        // ************************************************
        // pin synchronisers
        // ************************************************
        core_d.sclk_m = sclk_pin;
        core_d.sclk_s = core_q.sclk_m;
        core_d.sclk_p = core_q.sclk_s;
        core_d.cs_m = cs_n_pin;
        core_d.cs_s = core_q.cs_m;
        core_d.cs_p = core_q.cs_s;
        core_d.sdi_m = sdi_pin;
        core_d.sdi_s = core_q.sdi_m;
        // ************************************************
        // serial peripheral shifting
        // ************************************************
        if (cs_fall) begin
            resp24 = {status_byte(core_q.resp_cmd, alarm, core_q.resp_crcerr, general_summary,
                                  core_q.resp_kind, reset_flag), core_q.resp_data};
            core_d.out_sh = {resp24, check_enable ? crc8({8'h00, resp24}) : 8'h00};
            core_d.sdo = core_d.out_sh[31];
            core_d.lcnt = '0;
            core_d.ecnt = '0;
            if (core_q.clr_pend && !core_q.map) begin
                core_d.fault = 1'b0;
                core_d.fail_cnt = '0;
                core_d.clr_pend = 1'b0;
                core_d.sticky_clr = 1'b1;
            end
        end
        if (fall) begin
            core_d.rx_sh = {core_q.rx_sh[30:0], core_q.sdi_s};
            if (core_q.ecnt != 6'h3f) begin
                core_d.ecnt = core_q.ecnt + 6'h01;
            end
        end
        if (launch) begin
            core_d.out_sh = {core_q.out_sh[30:0], 1'b0};
            if (core_q.lcnt != 6'h3f) begin
                core_d.lcnt = core_q.lcnt + 6'h01;
            end
            // past the frame the input reappears one frame length later
            if (core_q.lcnt + 6'h01 < flen) begin
                core_d.sdo = core_q.out_sh[30];
            end else begin
                // a rising launch comes before that bit's falling sample, so the frame sits one place lower
                core_d.sdo = fall_edge_launch ? core_d.rx_sh[eidx] : core_d.rx_sh[eidx - 5'h01];
            end
        end
        // ************************************************
        // resynchronised execution
        // ************************************************
        if (core_q.pend) begin
            if (core_q.dly == `SYNC_CYC) begin
                core_d.pend = 1'b0;
                core_d.resp_kind = 1'b1;
                if (core_q.p_addr == `UBM_REG_ADDR) begin
                    if (core_q.p_wr) begin
                        core_d.map = core_q.p_data[`MAP_BIT];
                    end
                    core_d.resp_data = core_q.p_wr ? 16'h0000 : {15'h0000, core_q.map};
                end else begin
                    core_d.cmd_v = 1'b1;
                    core_d.resp_data = core_q.p_wr ? 16'h0000 : rd_data;
                end
                if (!core_q.p_wr && (core_q.p_addr == `FAULT_REG_ADDR || core_q.p_addr == `GEN_REG_ADDR)) begin
                    core_d.clr_pend = 1'b1;
                end
                if (core_q.p_uart && !core_q.p_wr) begin
                    core_d.tx_rd = 1'b1;
                end
            end else begin
                core_d.dly = core_q.dly + 10'h001;
            end
        end
        // partial frames and locked-out frames never reach the registers
        if (cs_rise && core_q.ecnt >= flen && !core_q.map) begin
            core_d.resp_cmd = f24[`RW_BIT];
            core_d.resp_crcerr = bad;
            if (bad) begin
                if (core_q.fail_cnt != 2'b11) begin
                    core_d.fail_cnt = core_q.fail_cnt + 2'b01;
                end
            end else if (f24[`ADDR_HI:`ADDR_LO] != `UBM_REG_ADDR) begin
                core_d.pend = 1'b1;
                core_d.dly = '0;
                core_d.p_wr = ~f24[`RW_BIT];
                core_d.p_addr = f24[`ADDR_HI:`ADDR_LO];
                core_d.p_data = f24[15:0];
                core_d.p_uart = 1'b0;
            end
        end
        // ************************************************
        // uart command packets
        // ************************************************
        if (ul.rx_break) begin
            core_d.ucnt = '0;
            core_d.uarm = 1'b1;
        end else if (ul.rx_err) begin
            core_d.uarm = 1'b0;
        end else if (ul.rx_valid && core_q.uarm) begin
            core_d.ush = {core_q.ush[15:0], ul.rx_byte};
            core_d.ucnt = core_q.ucnt + 2'b01;
            if (core_q.ucnt == `LAST_BYTE) begin
                core_d.uarm = 1'b0;
                if (core_q.map || core_d.ush[`ADDR_HI:`ADDR_LO] == `UBM_REG_ADDR) begin
                    core_d.resp_cmd = core_d.ush[`RW_BIT];
                    core_d.resp_crcerr = 1'b0;
                    core_d.pend = 1'b1;
                    core_d.dly = '0;
                    core_d.p_wr = ~core_d.ush[`RW_BIT];
                    core_d.p_addr = core_d.ush[`ADDR_HI:`ADDR_LO];
                    core_d.p_data = core_d.ush[15:0];
                    core_d.p_uart = 1'b1;
                end
            end
        end
        // ************************************************
        // uart output packets
        // ************************************************
        unique case (core_q.tx_st)
            TX_IDLE: begin
                if (core_q.tx_rd) begin
                    core_d.tx_rd = 1'b0;
                    core_d.tx_pkt = {status_byte(core_q.resp_cmd, alarm, 1'b0, general_summary, 1'b1,
                                                 reset_flag), core_q.resp_data};
                    core_d.tx_st = TX_BRK;
                    if (core_q.clr_pend) begin
                        core_d.fault = 1'b0;
                        core_d.fail_cnt = '0;
                        core_d.clr_pend = 1'b0;
                        core_d.sticky_clr = 1'b1;
                    end
                end else if (unsolicited_event_enable && core_q.ev_pend) begin
                    core_d.ev_pend = 1'b0;
                    if (ev) begin
                        core_d.tx_pkt = {status_byte(1'b0, alarm, 1'b0, general_summary, 1'b0, reset_flag),
                                         alarm ? fault_flag_value : general_flag_value};
                        core_d.tx_st = TX_BRK;
                    end
                end
            end
            TX_BRK: begin
                if (ul.tx_ready) begin
                    core_d.tx_st = TX_B0;
                end
            end
            TX_B0: begin
                if (ul.tx_ready) begin
                    core_d.tx_st = TX_B1;
                end
            end
            TX_B1: begin
                if (ul.tx_ready) begin
                    core_d.tx_st = TX_B2;
                end
            end
            TX_B2: begin
                if (ul.tx_ready) begin
                    core_d.tx_st = TX_IDLE;
                end
            end
        endcase
        if (ev && !core_q.ev_p) begin
            core_d.ev_pend = 1'b1;
        end
        core_d.ev_p = ev;
        // relatch last, from the count left after any clear; each clear also zeroes the count, so the clear wins its cycle
        if (frame_check_fail_limit != 2'b00 && core_d.fail_cnt >= frame_check_fail_limit) begin
            core_d.fault = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_q <= '0;
            core_q.cs_m <= 1'b1;
            core_q.cs_s <= 1'b1;
            core_q.cs_p <= 1'b1;
        end else begin
            core_q <= core_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign sdo_o = core_q.sdo;
    assign sdo_oe = ~core_q.cs_s & ~readback_disable & ~core_q.map;
    assign cmd_valid = core_q.cmd_v;
    assign cmd_write = core_q.p_wr;
    assign cmd_addr = core_q.p_addr;
    assign cmd_wdata = core_q.p_data;
    assign frame_check_fault = core_q.fault;
    assign fault_pin_n = ~(core_q.fault & alarm_action_en);
    assign break_framed_uart = core_q.map;
    assign sticky_clear = core_q.sticky_clr;
    assign ul.tx_valid = (core_q.tx_st != TX_IDLE);
    assign ul.tx_break = (core_q.tx_st == TX_BRK);
    assign ul.tx_byte = (core_q.tx_st == TX_B0) ? core_q.tx_pkt[23:16] :
                        (core_q.tx_st == TX_B1) ? core_q.tx_pkt[15:8] : core_q.tx_pkt[7:0];
endmodule
`default_nettype wire

// File: verification/serial_host_monitor.sv
// concurrent checks on the serial host port pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic sdo_oe,
    input wire logic readback_disable,
    input wire logic break_framed_uart,
    input wire logic cmd_valid,
    input wire logic [1:0] frame_check_fail_limit,
    input wire logic frame_check_fault,
    input wire logic alarm_action_en,
    input wire logic fault_pin_n
);
    // counts select-high cycles; saturates so long idle stretches stay legal
    logic [9:0] cs_hi_q;
    logic [9:0] cs_hi_d;
    always_comb cs_hi_d = !cs_n_pin ? 10'h000 : ((cs_hi_q == 10'h3ff) ? cs_hi_q : cs_hi_q + 10'h001);
    always_ff @(posedge clk) cs_hi_q <= !rst_n ? 10'h000 : cs_hi_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence cs_idle_s;
        cs_n_pin[*5];
    endsequence
    sequence cs_active_s;
        (!cs_n_pin)[*6];
    endsequence
    chk_oe_allowed: assert property (sdo_oe |-> !readback_disable && !break_framed_uart)
        else $error("output driven while readback is off");
    chk_oe_idle: assert property (cs_idle_s |-> !sdo_oe)
        else $error("output driven with select high");
    chk_oe_active: assert property (cs_active_s ##0 (!readback_disable && !break_framed_uart) |-> sdo_oe)
        else $error("output not driven during frame");
    chk_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    chk_valid_wait: assert property (cmd_valid |-> cs_hi_q >= 10'd300)
        else $error("command executed too soon after select rise");
    chk_fault_limit: assert property ($rose(frame_check_fault) |-> $past(frame_check_fail_limit) != 2'h0)
        else $error("fault set with limit zero");
    chk_pin_clear: assert property (!frame_check_fault |-> fault_pin_n)
        else $error("fault pin low without fault");
    chk_pin_set: assert property ((frame_check_fault && alarm_action_en)[*2] |-> !fault_pin_n)
        else $error("fault pin high with enabled fault");
endmodule
bind serial_host_port_frame_check serial_host_monitor mon (.clk(clk), .rst_n(rst_n),
    .cs_n_pin(cs_n_pin), .sdo_oe(sdo_oe), .readback_disable(readback_disable),
    .break_framed_uart(break_framed_uart), .cmd_valid(cmd_valid),
    .frame_check_fail_limit(frame_check_fail_limit), .frame_check_fault(frame_check_fault),
    .alarm_action_en(alarm_action_en), .fault_pin_n(fault_pin_n));
`default_nettype wire

// File: verification/spi_host_model.sv
// host model that clocks frames into the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic fall_edge_launch,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // idle-low clock, data changed on rising edges, 80 ns period
    task automatic xfer(input logic [33:0] d, input int n, output logic [31:0] q);
        logic b;
        b = 1'b0;
        q = 32'h0;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (10) @(negedge clk);
            // sample just before the launching edge; a released line reads inverted
            if (!fall_edge_launch) begin
                b = sdo_oe ? sdo_o : ~b;
                q = {q[30:0], b};
            end
            sclk = 1'b1;
            sdi = d[i];
            repeat (10) @(negedge clk);
            if (fall_edge_launch) begin
                b = sdo_oe ? sdo_o : ~b;
                q = {q[30:0], b};
            end
            sclk = 1'b0;
        end
        repeat (10) @(negedge clk);
        cs_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the serial host port with frame checking
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fel = 1'b0;
    logic rbd = 1'b0;
    logic cen = 1'b1;
    logic msk = 1'b1;
    logic aae = 1'b1;
    logic [1:0] lim = 2'h2;
    logic [15:0] rdd = 16'h0000;
    logic [31:0] rnd = 32'hee7d;
    logic [31:0] resp;
    logic [23:0] prev = 24'h000000;
    logic [23:0] pm = 24'hffffff;
    int failures = 0;
    int check_count = 0;
    wire sclk, cs_n, sdi, sdo_o, sdo_oe, cv, cw, fault, fpin_n;
    wire [6:0] ca;
    wire [15:0] cd;
    always #2 clk = ~clk;
    serial_host_port_frame_check #(.BIT_CYC(16'h0010)) DUT (.clk(clk), .rst_n(rst_n),
        .sclk_pin(sclk), .cs_n_pin(cs_n), .sdi_pin(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .serial_rx_pin(1'b1), .serial_tx_pin(), .readback_disable(rbd), .fall_edge_launch(fel),
        .check_enable(cen), .frame_check_fail_limit(lim), .fault_mask(msk), .alarm_action_en(aae),
        .unsolicited_event_enable(1'b0), .fault_summary(1'b0), .general_summary(1'b0),
        .reset_flag(rnd[7]), .fault_flag_value(rnd[15:0]), .general_flag_value(rnd[31:16]),
        .rd_data(rdd), .cmd_valid(cv), .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd),
        .frame_check_fault(fault), .fault_pin_n(fpin_n), .break_framed_uart(), .sticky_clear());
    spi_host_model host (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .fall_edge_launch(fel),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // msb first from zero, so a good frame leaves no remainder
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one frame, a check of the answer to the frame before, a bounded wait for its command
    task automatic frame(input logic [23:0] w, input int n, input logic [7:0] x, input logic ok, input logic chk);
        logic seen;
        logic [15:0] m;
        seen = 1'b0;
        m = {16{~w[23]}};
        @(negedge clk);
        rnd = lfsr(rnd);
        rdd = rnd[15:0];
        host.xfer((n == 24) ? {10'h000, w} : {2'b01, w, crc8(w) ^ x}, n, resp);
        if (chk) cmp(resp[31:8] & pm, (prev | {5'h00, rnd[7], 18'h00000}) & pm);
        if (chk) cmp(resp[7:0], crc8(resp[31:8]));
        prev = {w[23], 1'b0, x != 8'h00, 2'b01, 1'b0, 2'b00, w[23] ? rdd : 16'h0000};
        pm = (x != 8'h00) ? 24'ha00000 : 24'hffffff;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (cv === 1'b1 && !seen) cmp({cw, ca, cd & m}, {~w[23], w[22:16], w[15:0] & m});
            if (cv === 1'b1) seen = 1'b1;
        end
        cmp(seen, ok);
        $display("frame %h of %0d bits done", w, n);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        frame(24'h000000, 32, 8'h00, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            fel = i[1];
            frame({i[0], 2'b00, rnd[28:24], rnd[31:16]}, 32, 8'h00, 1'b1, 1'b1);
        end
        frame({1'b0, 7'h03, rnd[15:0]}, 32, 8'h01, 1'b0, 1'b1);
        frame({1'b0, 7'h04, rnd[15:0]}, 32, 8'h80, 1'b0, 1'b1);
        cmp({fault, fpin_n}, 2'b10);
        aae = 1'b0;
        @(negedge clk);
        cmp(fpin_n, 1'b1);
        aae = 1'b1;
        frame({1'b1, 7'h20, 16'h0000}, 32, 8'h00, 1'b1, 1'b1);
        frame(24'h000000, 32, 8'h00, 1'b1, 1'b1);
        cmp(fault, 1'b0);
        frame({1'b0, 7'h05, rnd[15:0]}, 20, 8'h00, 1'b0, 1'b0);
        frame({1'b0, 7'h06, rnd[15:0]}, 34, 8'h00, 1'b1, 1'b0);
        cmp(resp[1:0], 2'b01);
        frame(24'h000000, 32, 8'h00, 1'b1, 1'b1);
        @(negedge clk);
        cen = 1'b0;
        rbd = 1'b1;
        frame({1'b0, 7'h07, rnd[15:0]}, 24, 8'h00, 1'b1, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
